// ==== logic/itm_controller.sv ====
// Controller end: drives SCL from clk, runs one register access per
// command and queues read bytes in a FIFO. Bus pins sampled through syncs.
`timescale 1ns/1ps
module itm_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk, // System clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic in_valid, // Push request
	output logic in_ready, // Room available
	input wire logic [WIDTH-1:0] in_data, // Push data
	output logic out_valid, // Data available
	input wire logic out_ready, // Pop request
	output logic [WIDTH-1:0] out_data // Head word
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_reg;
	logic [AW:0] rd_reg;
	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;

	// Extra pointer bit tells full from empty
	assign in_ready = ~((wr_reg[AW] != rd_reg[AW]) & (wr_reg[AW-1:0] == rd_reg[AW-1:0]));
	assign out_valid = (wr_reg != rd_reg);
	assign out_data = mem[rd_reg[AW-1:0]];

	// Storage
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_reg[AW-1:0]] <= in_data;
		end
	end

	// Pointers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_reg <= '0;
			rd_reg <= '0;
		end else begin
			wr_reg <= wr_reg + (AW + 1)'(push);
			rd_reg <= rd_reg + (AW + 1)'(pop);
		end
	end
endmodule

module itm_controller (
	input wire logic clk, // System clock
	input wire logic rst_n, // Synchronous reset, active low
	itm_link_if.host link, // Bus and mode pins
	input wire logic cmd_valid, // Command request
	output logic cmd_ready, // Idle, command taken
	input wire logic cmd_read, // 1 read, 0 write
	input wire logic [7:0] cmd_index, // Register index
	input wire logic [7:0] cmd_wdata, // Write data
	input wire logic [3:0] cmd_count, // Read byte count, 0 as 1
	output logic done, // Command finished pulse
	output logic done_nack, // Target refused a byte
	output logic rd_valid, // Read byte available
	input wire logic rd_ready, // Read byte taken
	output logic [7:0] rd_data, // Read byte
	input wire logic sleep_req_n, // Sleep pin request, low sleeps
	input wire logic float_in, // Output float request
	output logic fault_seen_n // Synchronised fault pin
);
	itm_pkg::itm_hstate_t state_reg;
	logic [6:0] qtr_reg;
	logic [1:0] ph_reg;
	logic [3:0] bit_reg;
	logic [2:0] step_reg;
	logic [3:0] left_reg;
	logic [7:0] rx_reg;
	logic scl_low_reg;
	logic sda_low_reg;
	logic nack_reg;
	logic rd_cmd_reg;
	logic [7:0] idx_reg;
	logic [7:0] wd_reg;
	logic [1:0] sda_sync_reg;
	logic [1:0] flt_sync_reg;
	logic sleep_reg;
	logic float_reg;
	logic fifo_ready;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	wire sda_s = sda_sync_reg[1];
	wire tx_byte = (step_reg != 3'h4);
	wire [7:0] tx_data = (step_reg == 3'h0) ? {itm_pkg::DEV_ADDR, 1'b0} :
		(step_reg == 3'h1) ? idx_reg : (step_reg == 3'h2) ? wd_reg :
		{itm_pkg::DEV_ADDR, 1'b1};
	wire stall = (state_reg == itm_pkg::H_BYTE) & ~tx_byte & ~fifo_ready
		& (ph_reg == 2'h0) & (bit_reg == 4'h0);
	wire tick = (state_reg != itm_pkg::H_IDLE) & ~stall
		& (qtr_reg == 7'(itm_pkg::QTR_CYCLES - 1));
	wire byte_end = tick & (state_reg == itm_pkg::H_BYTE) & (ph_reg == 2'h3)
		& (bit_reg == 4'h8);
	wire last_rd = (left_reg == 4'h1);
	wire tx_bit_low = (bit_reg == 4'h8) ? (~tx_byte & ~last_rd)
		: (tx_byte & ~tx_data[3'(4'h7 - bit_reg)]);
	wire [3:0] bit_up = bit_reg + 4'h1;
	// Level for the coming bit, set while SCL is low
	wire next_low = (bit_up == 4'h8) ? (~tx_byte & ~last_rd)
		: (tx_byte & ~tx_data[3'(4'h7 - bit_up)]);
	wire push = byte_end & ~tx_byte;

	assign cmd_ready = (state_reg == itm_pkg::H_IDLE);

	// Read bytes wait here; a full queue holds SCL low before a read byte
	itm_fifo #(.WIDTH(itm_pkg::FIFO_WIDTH), .DEPTH(itm_pkg::FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(push),
		.in_ready(fifo_ready),
		.in_data(rx_reg),
		.out_valid(rd_valid),
		.out_ready(rd_ready),
		.out_data(rd_data)
	);

	// Pin synchronisers and mode pin drivers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sda_sync_reg <= 2'h3;
			flt_sync_reg <= 2'h3;
			sleep_reg <= 1'b0;
			float_reg <= 1'b0;
		end else begin
			sda_sync_reg <= {sda_sync_reg[0], link.sda};
			flt_sync_reg <= {flt_sync_reg[0], link.fault_n};
			sleep_reg <= sleep_req_n;
			float_reg <= float_in & sleep_req_n;
		end
	end

	// Quarter-bit timer sets a 400 kHz SCL
	always_ff @(posedge clk) begin
		if (!rst_n || tick || state_reg == itm_pkg::H_IDLE) begin
			qtr_reg <= 7'h0;
		end else if (!stall) begin
			qtr_reg <= qtr_reg + 7'h1;
		end
	end

	// ------------------------------------------------------------
	// Bus sequencer
	// ------------------------------------------------------------
	// Data moves only on entering phase 0 or in start/stop
	always_ff @(posedge clk) begin
		done <= 1'b0;
		if (!rst_n) begin
			state_reg <= itm_pkg::H_IDLE;
			{ph_reg, bit_reg, step_reg, left_reg, rx_reg} <= '0;
			{scl_low_reg, sda_low_reg, nack_reg, rd_cmd_reg, done_nack} <= '0;
			{idx_reg, wd_reg} <= '0;
		end else begin
			case (state_reg)
				itm_pkg::H_IDLE: begin
					if (cmd_valid) begin
						state_reg <= itm_pkg::H_START;
						{ph_reg, step_reg, nack_reg} <= '0;
						rd_cmd_reg <= cmd_read;
						idx_reg <= cmd_index;
						wd_reg <= cmd_wdata;
						left_reg <= (cmd_count == 4'h0) ? 4'h1 : cmd_count;
					end
				end
				itm_pkg::H_START: begin
					if (tick) begin
						ph_reg <= ph_reg + 2'h1;
						scl_low_reg <= ph_reg[1]; // Held low into the first bit
						sda_low_reg <= (ph_reg != 2'h0);
						if (ph_reg == 2'h3) begin
							state_reg <= itm_pkg::H_BYTE;
							bit_reg <= 4'h0;
							sda_low_reg <= tx_bit_low;
						end
					end
				end
				itm_pkg::H_BYTE: begin
					if (tick) begin
						ph_reg <= ph_reg + 2'h1;
						if (ph_reg == 2'h0) begin
							scl_low_reg <= 1'b0;
						end else if (ph_reg == 2'h1) begin
							if (bit_reg != 4'h8) begin
								rx_reg <= {rx_reg[6:0], sda_s};
							end else if (tx_byte) begin
								nack_reg <= sda_s;
							end
						end else if (ph_reg == 2'h2) begin
							scl_low_reg <= 1'b1;
						end else if (bit_reg != 4'h8) begin
							bit_reg <= bit_up;
							sda_low_reg <= next_low;
						end
					end
					if (byte_end) begin
						bit_reg <= 4'h0;
						sda_low_reg <= 1'b0;
						state_reg <= itm_pkg::H_BYTE;
						if (tx_byte && nack_reg) begin
							state_reg <= itm_pkg::H_STOP;
						end else if (step_reg == 3'h1 && rd_cmd_reg) begin
							state_reg <= itm_pkg::H_START;
							step_reg <= 3'h3;
						end else if (step_reg == 3'h2 || (step_reg == 3'h4 && last_rd)) begin
							state_reg <= itm_pkg::H_STOP;
						end else begin
							step_reg <= (step_reg == 3'h4) ? 3'h4 : step_reg + 3'h1;
							left_reg <= (step_reg == 3'h4) ? left_reg - 4'h1 : left_reg;
							sda_low_reg <= 1'b0;
						end
						if (!(step_reg == 3'h1 && rd_cmd_reg) && !(tx_byte && nack_reg)
							&& step_reg != 3'h2 && !(step_reg == 3'h4 && last_rd)) begin
							// First bit of the next byte; reads leave the line free
							sda_low_reg <= (step_reg == 3'h0) ? ~idx_reg[7]
								: (step_reg == 3'h1) ? ~wd_reg[7] : 1'b0;
						end
						if (tx_byte && nack_reg || step_reg == 3'h2
							|| (step_reg == 3'h4 && last_rd)) begin
							sda_low_reg <= 1'b1;
						end
					end
				end
				itm_pkg::H_STOP: begin
					if (tick) begin
						ph_reg <= ph_reg + 2'h1;
						scl_low_reg <= 1'b0;
						sda_low_reg <= (ph_reg == 2'h0);
						if (ph_reg == 2'h1) begin
							state_reg <= itm_pkg::H_IDLE;
							done <= 1'b1;
							done_nack <= nack_reg;
						end
					end
				end
				default: begin
					state_reg <= itm_pkg::H_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Pins
	// ------------------------------------------------------------
	assign link.host_scl_o = 1'b0;
	assign link.host_scl_oe = scl_low_reg;
	assign link.host_sda_o = 1'b0;
	assign link.host_sda_oe = sda_low_reg;
	assign link.sleep_n = sleep_reg;
	assign link.float_req = float_reg;
	assign fault_seen_n = flt_sync_reg[1];
endmodule

// ==== logic/itm_link_if.sv ====
// Pin bundle between the controller end and the target end.
// Open-drain lines are resolved here from each party's output enable.
`timescale 1ns/1ps
interface itm_link_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic fault_o;
	logic fault_oe;
	logic sleep_n;
	logic float_req;
	logic scl;
	logic sda;
	logic fault_n;

	// Wired-AND with pull-ups
	assign scl = ~(host_scl_oe & ~host_scl_o);
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
	assign fault_n = ~(fault_oe & ~fault_o);

	modport dev (input scl, input sda, input sleep_n, input float_req,
		output dev_sda_o, output dev_sda_oe, output fault_o, output fault_oe);
	modport host (input scl, input sda, input fault_n,
		output host_scl_o, output host_scl_oe, output host_sda_o, output host_sda_oe,
		output sleep_n, output float_req);
endinterface

// ==== logic/itm_pkg.sv ====
// Shared constants for the two-wire target and its controller end.
// Assumes a 125 MHz system clock on both ends.
package itm_pkg;
	// ------------------------------------------------------------
	// Bus address and register map
	// ------------------------------------------------------------
	localparam logic [6:0] DEV_ADDR = 7'h6c;
	localparam logic [7:0] REG_FAULT = 8'h01;
	localparam logic [7:0] REG_STATUS = 8'h02;
	localparam logic [7:0] REG_CTRL = 8'h03;
	localparam logic [7:0] CTRL_RESET = 8'h78;
	localparam logic [7:0] REG_NONE = 8'h00;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int FLT_DIAG = 2;
	localparam int FLT_OC = 3;
	localparam int FLT_UV = 4;
	localparam int FLT_OV = 5;
	localparam int FLT_DC = 6;
	localparam int FLT_OT = 7;
	localparam int ST_FAULT = 4;
	localparam int ST_DIAG = 5;
	localparam int ST_FLOAT = 6;
	localparam int ST_DRIVE = 7;
	localparam int CTRL_FREQ = 0;
	localparam int CTRL_GUARD_LSB = 3;
	localparam int CTRL_GAIN_LSB = 6;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 8000;
	localparam int WAKE_TIME_MS = 1;
	localparam int WAKE_CYCLES = WAKE_TIME_MS * 1000000000 / CLK_PERIOD_PS;
	localparam int SCL_QUARTER_NS = 625;
	localparam int QTR_CYCLES = (SCL_QUARTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 16;
	// ------------------------------------------------------------
	// State types
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		T_IDLE = 5'b00001,
		T_RX = 5'b00010,
		T_ACK = 5'b00100,
		T_TX = 5'b01000,
		T_MACK = 5'b10000
	} itm_tstate_t;
	typedef enum logic [3:0] {
		H_IDLE = 4'b0001,
		H_START = 4'b0010,
		H_BYTE = 4'b0100,
		H_STOP = 4'b1000
	} itm_hstate_t;
endpackage

// ==== logic/itm_target.sv ====
// Target end: two-wire register slave with mode and fault pin logic.
// Assumes link pins are asynchronous to clk; fault inputs are on clk.
`timescale 1ns/1ps
module itm_target #(
	parameter int WAKE_CYCLES = itm_pkg::WAKE_CYCLES
) (
	input wire logic clk, // System clock
	input wire logic rst_n, // Synchronous reset, active low
	itm_link_if.dev link, // Bus and mode pins
	input wire logic por_ok_n_low, // Supply above power-on level
	input wire logic thermal_shutdown, // Die over temperature
	input wire logic overcurrent_trip, // Output overcurrent
	input wire logic supply_low_trip, // Rail undervoltage
	input wire logic supply_high_trip, // Rail overvoltage
	input wire logic dc_offset_trip, // Output dc offset
	input wire logic diag_running, // Load check in progress
	input wire logic diag_done, // Load check result strobe
	input wire logic [3:0] diag_result, // Load short/open flags
	output logic osc_enable, // Oscillator run
	output logic drive_active, // Output stage switching
	output logic [1:0] gain_sel, // Gain code
	output logic [2:0] guard_level, // Voltage limiter code
	output logic freq_sel // Switching frequency select
);
	// ------------------------------------------------------------
	// Synchronisers
	// ------------------------------------------------------------
	logic [1:0] sleep_sync_reg;
	logic [1:0] por_sync_reg;
	logic [1:0] float_sync_reg;
	logic [2:0] scl_sync_reg;
	logic [2:0] sda_sync_reg;

	// Two flops each; third stage on bus lines is edge history only
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sleep_sync_reg <= 2'h0;
			por_sync_reg <= 2'h0;
			float_sync_reg <= 2'h0;
			scl_sync_reg <= 3'h7;
			sda_sync_reg <= 3'h7;
		end else begin
			sleep_sync_reg <= {sleep_sync_reg[0], link.sleep_n};
			por_sync_reg <= {por_sync_reg[0], por_ok_n_low};
			float_sync_reg <= {float_sync_reg[0], link.float_req};
			scl_sync_reg <= {scl_sync_reg[1:0], link.scl};
			sda_sync_reg <= {sda_sync_reg[1:0], link.sda};
		end
	end

	// ------------------------------------------------------------
	// Wake and reset
	// ------------------------------------------------------------
	wire awake = sleep_sync_reg[1] & por_sync_reg[1];
	wire dev_rst = ~rst_n | ~awake;
	logic [16:0] wake_cnt_reg;
	logic ready_reg;

	// Bus stays deaf until the wake delay has run out
	always_ff @(posedge clk) begin
		if (dev_rst) begin
			wake_cnt_reg <= 17'h0;
			ready_reg <= 1'b0;
		end else if (!ready_reg) begin
			wake_cnt_reg <= wake_cnt_reg + 17'h1;
			ready_reg <= (wake_cnt_reg == 17'(WAKE_CYCLES - 1));
		end
	end

	// ------------------------------------------------------------
	// Bus conditions
	// ------------------------------------------------------------
	wire scl_s = scl_sync_reg[1];
	wire sda_s = sda_sync_reg[1];
	wire scl_rise = scl_s & ~scl_sync_reg[2];
	wire scl_fall = ~scl_s & scl_sync_reg[2];
	wire start_det = scl_s & scl_sync_reg[2] & ~sda_s & sda_sync_reg[2];
	wire stop_det = scl_s & scl_sync_reg[2] & sda_s & ~sda_sync_reg[2];

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	itm_pkg::itm_tstate_t state_reg, state_next;
	logic [3:0] bit_reg, bit_next;
	logic [7:0] shift_reg, shift_next;
	logic [1:0] byte_reg, byte_next;
	logic rw_reg, rw_next;
	logic [7:0] ptr_reg, ptr_next;
	logic drive_reg, drive_next;
	logic [7:0] ctrl_reg;
	logic [7:0] fault_reg;
	logic [3:0] diag_reg;
	logic wr_en;

	// ------------------------------------------------------------
	// Status and read data
	// ------------------------------------------------------------
	wire diag_short = |{diag_reg[3], diag_reg[1:0]};
	wire fault_now = thermal_shutdown | overcurrent_trip | supply_low_trip
		| supply_high_trip | dc_offset_trip | diag_short;
	wire float_s = float_sync_reg[1];
	wire [7:0] status = {drive_active, float_s, diag_running, fault_now, diag_reg};
	wire [7:0] rd_data = (ptr_reg == itm_pkg::REG_FAULT) ? fault_reg :
		(ptr_reg == itm_pkg::REG_STATUS) ? status :
		(ptr_reg == itm_pkg::REG_CTRL) ? ctrl_reg : itm_pkg::REG_NONE;
	wire load_tx = scl_fall & (((state_reg == itm_pkg::T_ACK) & rw_reg)
		| (state_reg == itm_pkg::T_MACK));
	wire fault_rd = ready_reg & ~start_det & ~stop_det & load_tx
		& (ptr_reg == itm_pkg::REG_FAULT);
	wire ctrl_wr = wr_en & (ptr_reg == itm_pkg::REG_CTRL);
	wire addr_hit = (shift_reg[7:1] == itm_pkg::DEV_ADDR);
	wire [7:0] fault_set = {thermal_shutdown, dc_offset_trip, supply_high_trip,
		supply_low_trip, overcurrent_trip, diag_done & |{diag_result[3], diag_result[1:0]},
		2'b00};

	// ------------------------------------------------------------
	// Protocol engine next state
	// ------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		bit_next = bit_reg;
		shift_next = shift_reg;
		byte_next = byte_reg;
		rw_next = rw_reg;
		ptr_next = ptr_reg;
		drive_next = drive_reg;
		wr_en = 1'b0;
		if (!ready_reg) begin
			state_next = itm_pkg::T_IDLE;
			drive_next = 1'b0;
		end else if (start_det) begin
			state_next = itm_pkg::T_RX; // Repeated start lands here too
			bit_next = 4'h0;
			byte_next = 2'h0;
			drive_next = 1'b0;
		end else if (stop_det) begin
			state_next = itm_pkg::T_IDLE;
			drive_next = 1'b0;
		end else begin
			case (state_reg)
				itm_pkg::T_IDLE: begin
				end
				itm_pkg::T_RX: begin
					if (scl_rise) begin
						shift_next = {shift_reg[6:0], sda_s};
						bit_next = bit_reg + 4'h1;
					end else if (scl_fall && bit_reg == 4'h8) begin
						state_next = itm_pkg::T_ACK;
						drive_next = 1'b1;
						if (byte_reg != 2'h3) begin
							byte_next = byte_reg + 2'h1; // Saturates: no byte limit
						end
						if (byte_reg == 2'h0) begin
							rw_next = shift_reg[0];
							if (!addr_hit) begin
								state_next = itm_pkg::T_IDLE;
								drive_next = 1'b0;
							end
						end else if (byte_reg == 2'h1) begin
							ptr_next = shift_reg;
						end else begin
							wr_en = 1'b1;
							ptr_next = ptr_reg + 8'h1;
						end
					end
				end
				itm_pkg::T_ACK: begin
					if (scl_fall && !rw_reg) begin
						state_next = itm_pkg::T_RX; // Ack held through ninth clock
						bit_next = 4'h0;
						drive_next = 1'b0;
					end
				end
				itm_pkg::T_TX: begin
					if (scl_fall) begin
						if (bit_reg == 4'h8) begin
							state_next = itm_pkg::T_MACK;
							drive_next = 1'b0;
						end else begin
							shift_next = {shift_reg[6:0], 1'b0};
							drive_next = ~shift_reg[6];
							bit_next = bit_reg + 4'h1;
						end
					end
				end
				itm_pkg::T_MACK: begin
					if (scl_rise && sda_s) begin
						state_next = itm_pkg::T_IDLE; // Controller nack ends the read
					end
				end
				default: begin
					state_next = itm_pkg::T_IDLE;
					drive_next = 1'b0;
				end
			endcase
			if (load_tx) begin
				state_next = itm_pkg::T_TX;
				shift_next = rd_data;
				drive_next = ~rd_data[7];
				bit_next = 4'h1;
				ptr_next = ptr_reg + 8'h1;
			end
		end
	end

	// Engine state
	always_ff @(posedge clk) begin
		if (dev_rst) begin
			state_reg <= itm_pkg::T_IDLE;
			bit_reg <= 4'h0;
			shift_reg <= 8'h00;
			byte_reg <= 2'h0;
			rw_reg <= 1'b0;
			ptr_reg <= 8'h00;
			drive_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			bit_reg <= bit_next;
			shift_reg <= shift_next;
			byte_reg <= byte_next;
			rw_reg <= rw_next;
			ptr_reg <= ptr_next;
			drive_reg <= drive_next;
		end
	end

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	// Fault bits latch; a read clears them but a new event wins
	always_ff @(posedge clk) begin
		if (dev_rst) begin
			ctrl_reg <= itm_pkg::CTRL_RESET;
			fault_reg <= 8'h00;
			diag_reg <= 4'h0;
		end else begin
			if (ctrl_wr) begin
				ctrl_reg <= shift_reg;
			end
			fault_reg <= (fault_reg & ~{8{fault_rd}}) | fault_set;
			if (diag_done) begin
				diag_reg <= diag_result;
			end else if (diag_running) begin
				diag_reg <= 4'h0;
			end
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Never drives SCL: no clock stretching, no arbitration
	assign link.dev_sda_o = 1'b0;
	assign link.dev_sda_oe = drive_reg & ~dev_rst;
	assign link.fault_o = 1'b0;
	assign link.fault_oe = fault_now & awake; // Open load excluded
	assign osc_enable = awake;
	assign drive_active = ready_reg & ~float_s & ~fault_now & ~diag_running;
	assign gain_sel = ctrl_reg[itm_pkg::CTRL_GAIN_LSB +: 2];
	assign guard_level = ctrl_reg[itm_pkg::CTRL_GUARD_LSB +: 3];
	assign freq_sel = ctrl_reg[itm_pkg::CTRL_FREQ];
endmodule

// ==== tb/itm_link_chk.sv ====
// Link checks between the controller end and the target end.
// Assumes interface signals wired in by name, one clk domain.
`timescale 1ns/1ps
module itm_link_chk #(
	parameter int WAKE_CYCLES = 50
) (
	input wire logic clk, // System clock
	input wire logic rst_n, // Sync reset, low
	input wire logic scl, // Resolved clock line
	input wire logic sda, // Resolved data line
	input wire logic host_sda_oe, // Controller pulls data
	input wire logic dev_sda_oe, // Target pulls data
	input wire logic fault_oe, // Target pulls fault
	input wire logic sleep_n, // Sleep pin
	input wire logic float_req // Float pin
);
	// ----------------------------------------
	// Wake counter
	// ----------------------------------------
	int wake_cnt;
	// Counts from the pin, not the sync, so it errs on the quiet side
	always_ff @(posedge clk) begin
		if (!rst_n || !sleep_n) begin
			wake_cnt <= 0;
		end else if (wake_cnt < WAKE_CYCLES) begin
			wake_cnt <= wake_cnt + 1;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	a_sleep_sda_free: assert property (!sleep_n [*4] |-> !dev_sda_oe)
		else $error("data pulled while asleep");
	a_sleep_no_fault: assert property (!sleep_n [*4] |-> !fault_oe)
		else $error("fault pulled while asleep");
	a_wake_quiet: assert property (wake_cnt < WAKE_CYCLES |-> !dev_sda_oe)
		else $error("data pulled during wake delay");
	a_data_hold_high: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
		else $error("target data moved with clock high");
	a_ack_starts_low: assert property ($rose(dev_sda_oe) |-> !scl)
		else $error("target pull began with clock high");
	a_ack_ends_low: assert property ($fell(dev_sda_oe) |-> !scl)
		else $error("target pull ended with clock high");
	a_start_host_only: assert property (scl && $fell(sda) |-> host_sda_oe)
		else $error("start made by target");
	a_float_in_sleep: assert property (float_req |-> sleep_n)
		else $error("float pin high while asleep");
	a_high_moves_host: assert property (scl && $past(scl) && $changed(sda) |-> $changed(host_sda_oe))
		else $error("data moved with clock high outside start or stop");
	cover property ($rose(dev_sda_oe));
	cover property (scl && $fell(sda));
	cover property ($rose(fault_oe));
	cover property ($rose(float_req));
endmodule

// ==== tb/tb_top.sv ====
// Bench: controller and target ends joined by the link interface.
// Assumes the design package is compiled first; clk at 125 MHz.
`timescale 1ns/1ps
module tb_top;
	localparam int WAKE = 50;
	logic clk, rst_n, cmd_valid, cmd_ready, cmd_read, done, done_nack, rd_valid, rd_ready;
	logic sleep_req_n, float_in, fault_seen_n, osc_enable, drive_active, freq_sel;
	logic [7:0] cmd_index, cmd_wdata, rd_data;
	logic [3:0] cmd_count;
	logic [4:0] trip;
	logic diag_running, diag_done, por_ok;
	logic [3:0] diag_result;
	logic [1:0] gain_sel;
	logic [2:0] guard_level;
	int n_fail, samples_checked, i;
	itm_link_if itm_link_if_inst();
	itm_target #(.WAKE_CYCLES(WAKE)) itm_target_inst (.clk(clk), .rst_n(rst_n),
		.link(itm_link_if_inst.dev), .por_ok_n_low(por_ok), .thermal_shutdown(trip[4]),
		.overcurrent_trip(trip[0]), .supply_low_trip(trip[1]), .supply_high_trip(trip[2]),
		.dc_offset_trip(trip[3]), .diag_running(diag_running), .diag_done(diag_done),
		.diag_result(diag_result),
		.osc_enable(osc_enable), .drive_active(drive_active), .gain_sel(gain_sel),
		.guard_level(guard_level), .freq_sel(freq_sel));
	itm_controller itm_controller_inst (.clk(clk), .rst_n(rst_n), .link(itm_link_if_inst.host),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
		.cmd_index(cmd_index), .cmd_wdata(cmd_wdata), .cmd_count(cmd_count), .done(done),
		.done_nack(done_nack), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
		.sleep_req_n(sleep_req_n), .float_in(float_in), .fault_seen_n(fault_seen_n));
	itm_link_chk #(.WAKE_CYCLES(WAKE)) itm_link_chk_inst (.clk(clk), .rst_n(rst_n),
		.scl(itm_link_if_inst.scl), .sda(itm_link_if_inst.sda),
		.host_sda_oe(itm_link_if_inst.host_sda_oe), .dev_sda_oe(itm_link_if_inst.dev_sda_oe),
		.fault_oe(itm_link_if_inst.fault_oe), .sleep_n(itm_link_if_inst.sleep_n),
		.float_req(itm_link_if_inst.float_req));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checked=%0d mismatches=%0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Bounded wait; running out counts as a mismatch and ends the run
	task automatic wfor(ref logic s, input logic v, input int lim);
		for (int k = 0; k < lim && s !== v; k++) @(negedge clk);
		if (s !== v) begin
			n_fail++;
			tally_and_finish();
		end
	endtask
	task automatic cmd(input logic rd, input logic [7:0] idx, input logic [7:0] wd,
		input logic [3:0] cnt, input logic nk);
		@(posedge clk);
		cmd_valid <= 1'b1;
		{cmd_read, cmd_index, cmd_wdata, cmd_count} <= {rd, idx, wd, cnt};
		@(negedge clk);
		wfor(cmd_ready, 1'b1, 100);
		@(posedge clk);
		cmd_valid <= 1'b0;
		wfor(done, 1'b1, 40000);
		chk(done_nack, nk);
	endtask
	task automatic pop(input logic [7:0] exp);
		@(negedge clk);
		wfor(rd_valid, 1'b1, 20);
		chk(rd_data, exp);
		@(posedge clk);
		rd_ready <= 1'b1;
		@(posedge clk);
		rd_ready <= 1'b0;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_write_read();
		cmd(1'b0, itm_pkg::REG_CTRL, 8'h55, 4'h0, 1'b0);
		chk({2'h0, gain_sel, guard_level, freq_sel}, 8'h15);
		cmd(1'b1, itm_pkg::REG_FAULT, 8'h00, 4'h3, 1'b0);
		pop(8'h00);
		pop(8'h80);
		pop(8'h55);
		$display("write_read ended");
	endtask
	task automatic t_float();
		@(posedge clk);
		float_in <= 1'b1;
		repeat (8) @(negedge clk);
		chk(drive_active, 1'b0);
		@(posedge clk);
		float_in <= 1'b0;
		repeat (8) @(negedge clk);
		chk(drive_active, 1'b1);
		$display("float ended");
	endtask
	// Every trip source in turn; the sticky register then holds all five
	task automatic t_fault();
		cmd(1'b0, itm_pkg::REG_STATUS, 8'hff, 4'h0, 1'b0);
		for (i = 0; i < 5; i++) begin
			@(posedge clk);
			trip[i] <= 1'b1;
			wfor(fault_seen_n, 1'b0, 20);
			@(posedge clk);
			trip <= 5'h00;
			wfor(fault_seen_n, 1'b1, 20);
		end
		cmd(1'b1, itm_pkg::REG_FAULT, 8'h00, 4'h1, 1'b0);
		pop(8'hf8);
		cmd(1'b1, itm_pkg::REG_FAULT, 8'h00, 4'h2, 1'b0);
		pop(8'h00);
		pop(8'h80);
		$display("fault ended");
	endtask
	// Open load shows only in status; a new check run wipes it
	task automatic t_diag();
		@(posedge clk);
		{diag_done, diag_result} <= 5'h14;
		@(posedge clk);
		diag_done <= 1'b0;
		repeat (4) @(negedge clk);
		chk(fault_seen_n, 1'b1);
		cmd(1'b1, itm_pkg::REG_FAULT, 8'h00, 4'h2, 1'b0);
		pop(8'h00);
		pop(8'h84);
		@(posedge clk);
		diag_running <= 1'b1;
		cmd(1'b1, itm_pkg::REG_STATUS, 8'h00, 4'h0, 1'b0);
		pop(8'h20);
		@(posedge clk);
		diag_running <= 1'b0;
		$display("diag ended");
	endtask
	task automatic t_sleep();
		@(posedge clk);
		sleep_req_n <= 1'b0;
		repeat (8) @(negedge clk);
		chk(osc_enable, 1'b0);
		cmd(1'b0, itm_pkg::REG_CTRL, 8'h00, 4'h0, 1'b1);
		@(posedge clk);
		sleep_req_n <= 1'b1;
		repeat (WAKE + 8) @(negedge clk);
		chk(osc_enable, 1'b1);
		cmd(1'b1, itm_pkg::REG_CTRL, 8'h00, 4'h0, 1'b0);
		pop(itm_pkg::CTRL_RESET);
		chk({2'h0, gain_sel, guard_level, freq_sel}, 8'h1e);
		// Supply dip brings the same defaults back
		cmd(1'b0, itm_pkg::REG_CTRL, 8'h55, 4'h0, 1'b0);
		@(posedge clk);
		por_ok <= 1'b0;
		repeat (8) @(negedge clk);
		chk({2'h0, gain_sel, guard_level, freq_sel}, 8'h1e);
		$display("sleep ended");
	endtask
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		{rst_n, cmd_valid, cmd_read, rd_ready, float_in, trip} = '0;
		{diag_running, diag_done, diag_result} = '0;
		por_ok = 1'b1;
		{cmd_index, cmd_wdata, cmd_count} = '0;
		sleep_req_n = 1'b1;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (WAKE + 10) @(posedge clk);
		t_write_read();
		t_float();
		t_fault();
		t_diag();
		t_sleep();
		tally_and_finish();
	end
endmodule
